// File: hdl/chrc_pkg.sv
// package of constants, states and carrier types for the core halt/run control block
// Behaviour
// R1 - ack mpc stop when already debugger-stopped
// R2 - leave debugger stop only after both releases
// R3 - debugger resume alone keeps core stopped
// R4 - mpc run waits while debugger command busy; code holds only the debugger resume on busy
// R5 - run ack only after running, status low
// R6 - debugger stop during mpc stop is recorded
// R7 - power stop wakes on five wake sources
// R8 - wakeup honoured only with mie and meie
// R9 - pending external interrupts serviced once running
// R10 - stop bit quiesces before reporting halted
// R11 - dma served in both stopped states
// R12 - reserved control bits read zero
// R13 - control fields accept any, read legal
// R14 - stop bit acts on one, reads zero
// R15 - stop with irq-on-stop sets global enable
// R16 - irq-on-stop write alone leaves enable alone
// R17 - global enable stays set after wake
// R18 - debug mode ignores stop, enable untouched
// R19 - control register at csr address 0x7c6
// R20 - run handshake is four-phase
// R21 - controller requests run only in debug
// R22 - separate pending stop flags per source
package chrc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [11:0] CSR_PWR_CTRL_ADDR  = 12'h7c6; // power_mgmt_control
    localparam int          PWR_STOP_BIT       = 0;       // stop-initiate, write one
    localparam int          PWR_IRQ_ON_STOP_BIT = 1;      // interrupt-enable-on-stop
    localparam logic        IRQ_ON_STOP_RESET  = 1'b1;    // reset value of that bit
    localparam logic [31:0] CSR_READ_ZERO      = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // activity states of the core
    typedef enum logic [2:0] {
        CHRC_BOOT,         // first cycle after reset, start strap sampled
        CHRC_RUN,          // executing
        CHRC_QUIESCE_DBG,  // draining towards debugger_stopped_state
        CHRC_DBG_STOP,     // debugger_stopped_state, debug mode
        CHRC_QUIESCE_PWR,  // draining towards power_stopped_state
        CHRC_PWR_STOP      // power_stopped_state
    } chrc_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic halt_req;      // multi-core stop request, level
        logic run_req;       // multi-core run request, level
        logic reset_run_req; // start strap: 1 run, 0 start debug-stopped
    } chrc_mpc_in_t;

    typedef struct packed {
        logic halt_ack;          // stop acknowledge
        logic run_ack;           // run acknowledge
        logic debug_mode_status; // core is in debug mode
    } chrc_mpc_out_t;

    typedef struct packed {
        logic        wr_en;  // one-cycle csr write strobe
        logic        rd_en;  // one-cycle csr read strobe
        logic [11:0] addr;   // csr address
        logic [31:0] wdata;  // csr write data
    } chrc_csr_req_t;

    typedef struct packed {
        logic pmu_run_req; // power manager run request
        logic pic_wakeup;  // top-priority external interrupt wake
        logic soft_irq;    // software interrupt
        logic timer_irq;   // timer interrupt
        logic nmi;         // non-maskable interrupt
    } chrc_wake_t;

    // state of the four-phase responder
    typedef struct packed {
        logic ack;
    } chrc_hs_state_t;

    // state of the top block
    typedef struct packed {
        chrc_state_t   state;        // activity state
        logic          dbg_pend;     // debugger stop outstanding
        logic          mpc_pend;     // multi-core stop outstanding
        logic          irq_on_stop;  // stored interrupt-enable-on-stop
        logic          mie_set;      // one-cycle request to set global enable
        logic [31:0]   rdata;        // csr read data
    } chrc_top_state_t;

endpackage : chrc_pkg

// File: hdl/chrc_req_ack.sv
// four-phase request/acknowledge responder used for both multi-core handshakes
`timescale 1ns/1ps
module chrc_req_ack (
    input  wire logic ref_clk_i,  // core clock
    input  wire logic arst_n_i,   // async reset, active low
    input  wire logic req_i,      // request level from the controller
    input  wire logic grant_i,    // condition that allows the acknowledge
    output logic      ack_o,      // acknowledge level
    output logic      rise_o      // one-cycle pulse in the cycle before the acknowledge rises
);

    chrc_pkg::chrc_hs_state_t st_reg;  // registered state
    chrc_pkg::chrc_hs_state_t st_next; // next state

    ////////////////////////////////////////////////////////////////////////////////
    // raise on request plus grant, drop only once the request has gone
    always_comb begin
        st_next = st_reg;
        if (!st_reg.ack && req_i && grant_i) begin
            st_next.ack = 1'b1; // R20
        end else if (st_reg.ack && !req_i) begin
            st_next.ack = 1'b0; // R20
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ack held high for as long as the request stays up
    assign ack_o  = st_reg.ack;
    assign rise_o = st_next.ack && !st_reg.ack;

endmodule : chrc_req_ack

// File: hdl/chrc_top.sv
// core halt/run arbitration between debugger, multi-core controller and power manager
`timescale 1ns/1ps
module chrc_top (
    input  wire logic                    ref_clk_i,        // core clock, 40 MHz
    input  wire logic                    arst_n_i,         // async reset, active low
    // multi-core debug controller
    input  wire chrc_pkg::chrc_mpc_in_t  mpc_i,            // stop/run requests, strap
    output chrc_pkg::chrc_mpc_out_t      mpc_o,            // acks and debug status
    // core debugger
    input  wire logic                    dbg_halt_req_i,   // debugger stop, pulse
    input  wire logic                    dbg_resume_req_i, // debugger resume, pulse
    input  wire logic                    dbg_cmd_busy_i,   // abstract command running
    output logic                         dbg_halted_o,     // core in debug mode
    // power manager and wake sources
    input  wire logic                    pmu_halt_req_i,   // power manager stop request
    input  wire chrc_pkg::chrc_wake_t    wake_i,           // wake sources
    input  wire logic                    mstatus_mie_i,    // global machine irq enable
    input  wire logic                    mie_meie_i,       // machine external irq enable
    output logic                         mie_set_o,        // set global enable, pulse
    output logic                         pwr_halted_o,     // gracefully stopped
    // pipeline
    input  wire logic                    core_idle_i,      // pipeline fully drained
    output logic                         quiesce_req_o,    // stop issuing instructions
    output logic                         core_run_o,       // core may execute
    // external interrupts
    input  wire logic                    ext_irq_pend_i,   // pending, above threshold
    output logic                         ext_irq_take_o,   // take it now
    // direct memory access
    input  wire logic                    dma_req_i,        // dma access request
    output logic                         dma_gnt_o,        // dma access granted
    // csr port
    input  wire chrc_pkg::chrc_csr_req_t csr_i,            // csr access
    output logic [31:0]                  csr_rdata_o       // csr read data, registered
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    chrc_pkg::chrc_top_state_t st_reg;       // registered state, apart from the two handshake acks
    chrc_pkg::chrc_top_state_t st_next;      // its next value
    logic                      halt_ack;     // stop acknowledge level
    logic                      run_ack;      // run acknowledge level
    logic                      in_debug;     // registered debug mode
    logic                      in_run;       // registered running state
    logic                      csr_hit;      // access to power_mgmt_control
    logic                      fw_stop;      // firmware writes the stop bit
    logic                      wake;         // any wake reason in power stop
    logic                      stop_pend;    // some debug stop outstanding

    assign in_debug  = (st_reg.state == chrc_pkg::CHRC_DBG_STOP);
    assign in_run    = (st_reg.state == chrc_pkg::CHRC_RUN);
    assign stop_pend = st_reg.dbg_pend || st_reg.mpc_pend;

    ////////////////////////////////////////////////////////////////////////////////
    // multi-core stop handshake: ack once the core sits in debug mode, which also
    // covers a stop arriving while the debugger already holds the core
    chrc_req_ack u_halt_hs (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .req_i     (mpc_i.halt_req),
        .grant_i   (in_debug),       // R1
        .ack_o     (halt_ack),
        .rise_o    ()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // multi-core run handshake: ack only from the running state, which is entered
    // one edge before, so debug status is already low when the ack rises
    chrc_req_ack u_run_hs (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .req_i     (mpc_i.run_req),
        .grant_i   (in_run),         // R5
        .ack_o     (run_ack),
        .rise_o    ()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // csr decode
    always_comb begin
        csr_hit = 1'b0;
        if (csr_i.addr == chrc_pkg::CSR_PWR_CTRL_ADDR) begin
            csr_hit = 1'b1; // R19
        end else begin
            csr_hit = 1'b0;
        end
    end

    // the stop bit only counts when written as one from the running state;
    // in debug mode it is dropped on the floor
    assign fw_stop = csr_i.wr_en && csr_hit && in_run &&
                     csr_i.wdata[chrc_pkg::PWR_STOP_BIT]; // R14 R18

    ////////////////////////////////////////////////////////////////////////////////
    // wake qualification for the power stopped state
    always_comb begin
        wake = wake_i.pmu_run_req ||
               (wake_i.pic_wakeup && mstatus_mie_i && mie_meie_i) || // R8
               wake_i.soft_irq || wake_i.timer_irq || wake_i.nmi;     // R7
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        st_next         = st_reg;
        st_next.mie_set = 1'b0;

        // pending flags: a debugger stop in the same cycle as its resume wins
        if (st_reg.mpc_pend && mpc_i.run_req && in_debug) begin
            st_next.mpc_pend = 1'b0; // R22
        end
        if (mpc_i.halt_req && !halt_ack && !st_reg.mpc_pend) begin
            st_next.mpc_pend = 1'b1; // R2 R22
        end
        // a busy debugger command holds off its own resume
        if (st_reg.dbg_pend && dbg_resume_req_i && !dbg_cmd_busy_i) begin
            st_next.dbg_pend = 1'b0; // R4
        end
        if (dbg_halt_req_i) begin
            st_next.dbg_pend = 1'b1; // R6
        end

        // csr write: stored bit takes any value, it is a single legal bit
        if (csr_i.wr_en && csr_hit) begin
            st_next.irq_on_stop = csr_i.wdata[chrc_pkg::PWR_IRQ_ON_STOP_BIT]; // R13 R16
        end

        // csr read: reserved bits and the stop bit read zero
        st_next.rdata = chrc_pkg::CSR_READ_ZERO;
        if (csr_i.rd_en && csr_hit) begin
            st_next.rdata[chrc_pkg::PWR_IRQ_ON_STOP_BIT] = st_reg.irq_on_stop; // R12 R14
        end else if (csr_i.rd_en) begin
            st_next.rdata = chrc_pkg::CSR_READ_ZERO; // unmapped address
        end

        // activity state machine
        case (st_reg.state)
            chrc_pkg::CHRC_BOOT: begin
                // strap says whether to start in debug mode
                if (!mpc_i.reset_run_req) begin
                    st_next.mpc_pend = 1'b1;
                    st_next.state    = chrc_pkg::CHRC_QUIESCE_DBG;
                end else begin
                    st_next.state    = chrc_pkg::CHRC_RUN;
                end
            end
            chrc_pkg::CHRC_RUN: begin
                // a debug stop outranks a power stop
                if (stop_pend || dbg_halt_req_i ||
                    (mpc_i.halt_req && !halt_ack)) begin
                    st_next.state = chrc_pkg::CHRC_QUIESCE_DBG;
                end else if (fw_stop) begin
                    st_next.state = chrc_pkg::CHRC_QUIESCE_PWR; // R10
                    // enable set together with the stop, from the value written now
                    st_next.mie_set =
                        csr_i.wdata[chrc_pkg::PWR_IRQ_ON_STOP_BIT]; // R15
                end else if (pmu_halt_req_i) begin
                    st_next.state = chrc_pkg::CHRC_QUIESCE_PWR;
                end
            end
            chrc_pkg::CHRC_QUIESCE_DBG: begin
                // wait for the pipeline to drain before reporting debug mode
                if (core_idle_i) begin
                    st_next.state = chrc_pkg::CHRC_DBG_STOP;
                end
            end
            chrc_pkg::CHRC_DBG_STOP: begin
                // both sources must have released before the core may run
                if (!st_next.dbg_pend && !st_next.mpc_pend) begin
                    st_next.state = chrc_pkg::CHRC_RUN; // R2 R3
                end
            end
            chrc_pkg::CHRC_QUIESCE_PWR: begin
                // graceful: report stopped only once fully drained
                if (stop_pend) begin
                    st_next.state = chrc_pkg::CHRC_QUIESCE_DBG;
                end else if (core_idle_i) begin
                    st_next.state = chrc_pkg::CHRC_PWR_STOP; // R10
                end
            end
            chrc_pkg::CHRC_PWR_STOP: begin
                // the core is already drained, debug entry is direct; leaving
                // does not touch the global enable, it stays as the core left it
                if (stop_pend) begin
                    st_next.state = chrc_pkg::CHRC_DBG_STOP;
                end else if (wake) begin
                    st_next.state = chrc_pkg::CHRC_RUN; // R7 R17
                end
            end
            default: begin
                st_next.state = chrc_pkg::CHRC_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg             <= '0;
            st_reg.state       <= chrc_pkg::CHRC_BOOT;
            st_reg.irq_on_stop <= chrc_pkg::IRQ_ON_STOP_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign mpc_o.halt_ack          = halt_ack;
    assign mpc_o.run_ack           = run_ack;                           // R20
    assign mpc_o.debug_mode_status = in_debug;                          // R3
    assign dbg_halted_o            = in_debug;
    assign pwr_halted_o            = (st_reg.state == chrc_pkg::CHRC_PWR_STOP);
    assign mie_set_o               = st_reg.mie_set;                    // R15
    assign quiesce_req_o           = !in_run && (st_reg.state != chrc_pkg::CHRC_BOOT);
    assign core_run_o              = in_run;
    assign csr_rdata_o             = st_reg.rdata;

    // interrupts below the wake level just wait; they are taken once running
    assign ext_irq_take_o = ext_irq_pend_i && in_run;                   // R8 R9

    // dma never depends on the activity state; it is simply served in all of them
    assign dma_gnt_o = dma_req_i;                                       // R11

endmodule : chrc_top

// File: sim/chrc_props.sv
// concurrent checks on the ports of the halt/run control block
`timescale 1ns/1ps
module chrc_props (
    input wire logic                    ref_clk_i,
    input wire logic                    arst_n_i,
    input wire chrc_pkg::chrc_mpc_in_t  mpc_i,
    input wire chrc_pkg::chrc_mpc_out_t mpc_o,
    input wire logic                    dbg_halt_req_i,
    input wire logic                    dbg_halted_o,
    input wire chrc_pkg::chrc_wake_t    wake_i,
    input wire logic                    mstatus_mie_i,
    input wire logic                    mie_meie_i,
    input wire logic                    mie_set_o,
    input wire logic                    pwr_halted_o,
    input wire logic                    core_idle_i,
    input wire logic                    quiesce_req_o,
    input wire logic                    core_run_o,
    input wire logic                    ext_irq_pend_i,
    input wire logic                    ext_irq_take_o,
    input wire logic                    dma_req_i,
    input wire logic                    dma_gnt_o,
    input wire chrc_pkg::chrc_csr_req_t csr_i,
    input wire logic [31:0]             csr_rdata_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // one clock domain
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic wake_any; // some wake source that counts in power stop
    logic wr_pm;    // write aimed at the power control register
    assign wake_any = wake_i.pmu_run_req | wake_i.soft_irq | wake_i.timer_irq | wake_i.nmi
                    | (wake_i.pic_wakeup & mstatus_mie_i & mie_meie_i);
    assign wr_pm = csr_i.wr_en && csr_i.addr == chrc_pkg::CSR_PWR_CTRL_ADDR;
    // stop entry: one-cycle enable pulse while draining
    sequence s_stop_pulse;
        mie_set_o && quiesce_req_o ##1 !mie_set_o;
    endsequence
    // nothing moves towards power stop for two cycles
    sequence s_no_stop;
        !mie_set_o && !pwr_halted_o ##1 !pwr_halted_o;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    chk_dma_pass: assert property (dma_gnt_o == dma_req_i)
        else $error("dma grant differs from request");
    chk_irq_running: assert property (ext_irq_take_o == (ext_irq_pend_i && core_run_o))
        else $error("external irq taken outside running");
    chk_read_zero: assert property (csr_rdata_o[31:2] == 30'h0 && !csr_rdata_o[0])
        else $error("reserved or stop bit read nonzero");
    chk_ack_after_run: assert property ($rose(mpc_o.run_ack) |->
        core_run_o && !mpc_o.debug_mode_status && !$past(mpc_o.debug_mode_status))
        else $error("run ack before leaving debug mode");
    chk_run_release: assert property (mpc_o.run_ack && !mpc_i.run_req |=> !mpc_o.run_ack)
        else $error("run ack held after request dropped");
    chk_halt_release: assert property (mpc_o.halt_ack && !mpc_i.halt_req |=> !mpc_o.halt_ack)
        else $error("halt ack held after request dropped");
    chk_wake_exit: assert property (pwr_halted_o && wake_any |=> !pwr_halted_o)
        else $error("wake source did not end power stop");
    chk_stay_stopped: assert property (pwr_halted_o && !wake_any && !mpc_i.halt_req
        && !dbg_halt_req_i && !$past(dbg_halt_req_i) |=> pwr_halted_o)
        else $error("power stop left without wake");
    chk_drain_first: assert property ($rose(pwr_halted_o) |->
        $past(quiesce_req_o) && $past(core_idle_i))
        else $error("power stop reported before drain");
    chk_stop_ie: assert property (wr_pm && core_run_o && csr_i.wdata[1:0] == 2'b11
        && !mpc_i.halt_req && !dbg_halt_req_i |=> s_stop_pulse)
        else $error("stop with irq enable gave no pulse");
    chk_no_setie: assert property (wr_pm && !(csr_i.wdata[1] && csr_i.wdata[0]) |=> !mie_set_o)
        else $error("enable set without stop and irq bit");
    chk_dbg_ignore: assert property (wr_pm && dbg_halted_o |=> s_no_stop)
        else $error("stop write acted in debug mode");
endmodule : chrc_props

bind chrc_top chrc_props u_props (.ref_clk_i, .arst_n_i, .mpc_i, .mpc_o, .dbg_halt_req_i,
    .dbg_halted_o, .wake_i, .mstatus_mie_i, .mie_meie_i, .mie_set_o, .pwr_halted_o,
    .core_idle_i, .quiesce_req_o, .core_run_o, .ext_irq_pend_i, .ext_irq_take_o, .dma_req_i,
    .dma_gnt_o, .csr_i, .csr_rdata_o);

// File: sim/chrc_mpc_model.sv
// multi-core debug controller model, four-phase stop and run handshakes
`timescale 1ns/1ps
module chrc_mpc_model (
    input  wire logic                    ref_clk_i, // core clock
    input  wire chrc_pkg::chrc_mpc_out_t mpc_o,     // acks and debug status
    output chrc_pkg::chrc_mpc_in_t       mpc_i      // requests and start strap
);
    // start strap fixed to running; requests idle low
    initial mpc_i = '{halt_req: 1'b0, run_req: 1'b0, reset_run_req: 1'b1};
    ////////////////////////////////////////////////////////////////////////////////
    // raise one request; run is only asked for once debug mode shows
    task automatic raise(input bit run);
        int n;
        for (n = 0; n < 60 && run && mpc_o.debug_mode_status !== 1'b1; n++)
            @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        if (run) mpc_i.run_req = 1'b1;
        else mpc_i.halt_req = 1'b1;
    endtask : raise
    // hold until acked, linger lag cycles (slow side), drop, await ack fall
    task automatic finish(input bit run, input int lag, output bit ok);
        int n;
        for (n = 0; n < 80 && (run ? mpc_o.run_ack : mpc_o.halt_ack) !== 1'b1; n++)
            @(negedge ref_clk_i);
        ok = (run ? mpc_o.run_ack : mpc_o.halt_ack) === 1'b1;
        repeat (lag) @(negedge ref_clk_i);
        if (run) mpc_i.run_req = 1'b0;
        else mpc_i.halt_req = 1'b0;
        // next request only after the ack is gone, never back to back
        for (n = 0; n < 80 && (run ? mpc_o.run_ack : mpc_o.halt_ack) !== 1'b0; n++)
            @(negedge ref_clk_i);
        ok = ok && (run ? mpc_o.run_ack : mpc_o.halt_ack) === 1'b0;
    endtask : finish
endmodule : chrc_mpc_model

// File: sim/chrc_top_test.sv
// self-checking bench for the core halt/run control block
`timescale 1ns/1ps
module chrc_top_test;
    logic ref_clk_i = 1'b0, arst_n_i = 1'b0, dbg_halt_req_i = 1'b0, dbg_resume_req_i = 1'b0;
    logic dbg_cmd_busy_i = 1'b0, pmu_halt_req_i = 1'b0, mstatus_mie_i = 1'b0, mie_meie_i = 1'b0;
    logic core_idle_i = 1'b1, ext_irq_pend_i = 1'b0, dma_req_i = 1'b0;
    logic dbg_halted_o, mie_set_o, pwr_halted_o, quiesce_req_o, core_run_o, ext_irq_take_o;
    logic dma_gnt_o;
    logic [31:0] csr_rdata_o;
    chrc_pkg::chrc_mpc_in_t  mpc_i;
    chrc_pkg::chrc_mpc_out_t mpc_o;
    chrc_pkg::chrc_wake_t    wake_i = '0;
    chrc_pkg::chrc_csr_req_t csr_i = '0;
    logic [31:0] exp_q[$]; // expected read data, oldest first
    int n_mismatch = 0, samples_checked = 0;
    bit ok;

    always #12.5 ref_clk_i = ~ref_clk_i;
    chrc_top dut (.ref_clk_i, .arst_n_i, .mpc_i, .mpc_o, .dbg_halt_req_i, .dbg_resume_req_i,
        .dbg_cmd_busy_i, .dbg_halted_o, .pmu_halt_req_i, .wake_i, .mstatus_mie_i, .mie_meie_i,
        .mie_set_o, .pwr_halted_o, .core_idle_i, .quiesce_req_o, .core_run_o, .ext_irq_pend_i,
        .ext_irq_take_o, .dma_req_i, .dma_gnt_o, .csr_i, .csr_rdata_o);
    chrc_mpc_model mpc (.ref_clk_i, .mpc_o, .mpc_i);
    ////////////////////////////////////////////////////////////////////////////////
    // random dma, pending irqs and slow drain
    always @(negedge ref_clk_i) if (arst_n_i) begin
        dma_req_i = 1'($urandom % 2);
        ext_irq_pend_i = 1'($urandom % 2);
        core_idle_i = ($urandom % 4) != 0;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    task automatic final_report();
        if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // csr accesses; a read notes its expectation for the watcher
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge ref_clk_i);
        csr_i = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk_i);
        csr_i.wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(negedge ref_clk_i);
        exp_q.push_back(e);
        csr_i = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 32'h0};
        @(negedge ref_clk_i);
        csr_i.rd_en = 1'b0;
    endtask : rd
    // watcher: read data is registered by the edge that takes the strobe
    always @(posedge ref_clk_i) if (csr_i.rd_en === 1'b1) begin
        #2;
        if (exp_q.size() == 0) chk("read queue", 32'h1, 32'h0);
        else chk("csr_rdata_o", exp_q.pop_front(), csr_rdata_o);
    end
    // debugger pulse: 0 stop, 1 resume
    task automatic pulse(input bit res);
        @(negedge ref_clk_i);
        if (res) dbg_resume_req_i = 1'b1;
        else dbg_halt_req_i = 1'b1;
        @(negedge ref_clk_i);
        dbg_resume_req_i = 1'b0;
        dbg_halt_req_i = 1'b0;
    endtask : pulse
    // bounded wait: k 0 debug stop, 1 running, 2 power stop
    task automatic wait_hi(input int k);
        int n;
        for (n = 0; n < 80; n++) begin
            @(negedge ref_clk_i);
            if ((k == 0 ? dbg_halted_o : k == 1 ? core_run_o : pwr_halted_o) === 1'b1) return;
        end
        chk("wait bound", 32'h1, 32'h0);
        final_report();
    endtask : wait_hi
    task automatic hs_end(input bit run);
        mpc.finish(run, int'($urandom % 4), ok);
        if (!ok) begin
            chk("handshake bound", 32'h1, 32'h0);
            final_report();
        end
    endtask : hs_end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(77411));
        repeat (5) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        wait_hi(1);
        rd(12'h7c6, 32'h2);
        wr(12'h7c6, 32'hffff_fffc);
        rd(12'h7c6, 32'h0);
        wr(12'h7c6, 32'h2);
        rd(12'h7c6, 32'h2);
        wr(12'h7c2, 32'h3);
        rd(12'h7c2, 32'h0);
        chk("core_run_o", 32'h1, core_run_o);
        // every wake source once; stop by power manager, then by the stop bit
        for (int k = 0; k < 5; k++) begin
            if (k == 0) pmu_halt_req_i = 1'b1;
            else wr(12'h7c6, k[0] ? 32'h3 : 32'h1);
            wait_hi(2);
            pmu_halt_req_i = 1'b0;
            chk("core_run_o", 32'h0, core_run_o);
            wake_i = chrc_pkg::chrc_wake_t'(5'h10 >> k);
            if (k == 1) begin
                repeat (6) @(negedge ref_clk_i);
                chk("pwr_halted_o", 32'h1, pwr_halted_o);
                mstatus_mie_i = 1'b1;
                mie_meie_i = 1'b1;
            end
            wait_hi(1);
            wake_i = '0;
            chk("pwr_halted_o", 32'h0, pwr_halted_o);
        end
        // both stop sources in each order of stop and of release
        for (int s = 0; s < 4; s++) begin
            if (s[1]) begin
                pulse(1'b0);
                wait_hi(0);
            end
            mpc.raise(1'b0);
            hs_end(1'b0);
            if (!s[1]) pulse(1'b0);
            chk("dbg_halted_o", 32'h1, dbg_halted_o);
            if (s[0]) begin
                mpc.raise(1'b1);
                dbg_cmd_busy_i = 1'b1;
                pulse(1'b1);
                repeat (4) @(negedge ref_clk_i);
                chk("dbg_halted_o", 32'h1, dbg_halted_o);
                dbg_cmd_busy_i = 1'b0;
                pulse(1'b1);
            end else begin
                pulse(1'b1);
                repeat (4) @(negedge ref_clk_i);
                chk("debug_mode_status", 32'h1, mpc_o.debug_mode_status);
                mpc.raise(1'b1);
            end
            hs_end(1'b1);
            chk("core_run_o", 32'h1, core_run_o);
        end
        // debug mode: stop bit ignored, irq-on-stop still stored
        pulse(1'b0);
        wait_hi(0);
        wr(12'h7c6, 32'h3);
        rd(12'h7c6, 32'h2);
        chk("pwr_halted_o", 32'h0, pwr_halted_o);
        wr(12'h7c6, 32'h0);
        rd(12'h7c6, 32'h0);
        pulse(1'b1);
        wait_hi(1);
        repeat (3) @(negedge ref_clk_i);
        final_report();
    end
endmodule : chrc_top_test
